// ===== host_processor_port_front_end_test.sv
/*
 * Self-checking bench for the host port front end, with host model and back-end memory.
 * Assumes the host model is compiled first and a 20 MHz core clock.
 */
`default_nettype none

module host_processor_port_front_end_test
	import hpf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	wire logic host_clk;
	wire logic [2:0] sel;
	wire logic cs_n;
	wire logic wr;
	wire logic [14:0] addr;
	wire logic [7:0] hdata;
	wire logic strobe_n;
	wire logic be;
	wire logic acs;
	wire logic [7:0] dout;
	wire logic oe_n;
	wire logic ack;
	wire logic [14:0] a_addr;
	wire logic [7:0] a_wdata;
	wire logic a_wr;
	wire logic a_rd;
	wire logic a_be;
	wire logic [7:0] rdata;
	logic [7:0] mem [0:32767];
	logic [14:0] w_addr;
	logic [14:0] r_addr;
	logic [7:0] w_data;
	logic w_be;
	int n_wr = 0;
	int n_rd = 0;
	int cycles = 0;
	int err_count = 0;
	int compares = 0;

	hpf_host_port DUT (.clk_in(clk_in), .reset_in(reset_in), .host_clk_in(host_clk),
		.host_personality_select_in(sel), .chip_select_n_in(cs_n), .write_or_rw_in(wr),
		.host_addr_in(addr), .host_data_in(hdata), .read_or_data_strobe_n_in(strobe_n),
		.host_byte_enable_in(be), .address_capture_strobe_in(acs), .host_data_out(dout),
		.host_data_oe_n_out(oe_n), .transfer_acknowledge_out(ack), .access_addr_out(a_addr),
		.access_wdata_out(a_wdata), .access_write_out(a_wr), .access_read_out(a_rd),
		.access_byte_enable_out(a_be), .access_rdata_in(rdata));

	hpf_host_model host (.clk_in(clk_in), .dev_data_in(dout), .dev_oe_n_in(oe_n),
		.host_clk_out(host_clk), .sel_out(sel), .cs_n_out(cs_n), .wr_out(wr), .addr_out(addr),
		.data_out(hdata), .strobe_n_out(strobe_n), .be_out(be), .acs_out(acs));

	always #25 clk_in = ~clk_in;

	// ----------------------------------------
	// Back end and pulse monitor
	// ----------------------------------------
	// Back end answers at once from the held access address; the port takes the byte
	// at the edge that ends its read pulse, or in sync modes at the next host clock edge
	assign rdata = mem[a_addr];

	// Count pulses and cycles; ceiling cuts a hang
	always @(posedge clk_in) begin
		cycles++;
		if (a_wr === 1'b1) begin
			n_wr++;
			w_addr <= a_addr;
			w_data <= a_wdata;
			w_be <= a_be;
			mem[a_addr] <= a_wdata;
		end
		if (a_rd === 1'b1) begin
			n_rd++;
			r_addr <= a_addr;
		end
		if (cycles > 3000) begin
			err_count++;
			$display("wrong value at %0t: run timed out", $time);
			wrap_up();
		end
	end

	// ----------------------------------------
	// Compare and helper tasks
	// ----------------------------------------
	task automatic check_flag(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %b", $time, what, got);
		end
	endtask : check_flag

	task automatic check_word(input logic [14:0] got, input logic [14:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h", $time, what, got);
		end
	endtask : check_word

	task automatic do_reset(input logic [2:0] code);
		host.idle(code);
		reset_in = 1'b1;
		host.tick(16);
		reset_in = 1'b0;
		host.tick(2);
		n_wr = 0;
		n_rd = 0;
		check_flag(oe_n, 1'b1, "oe after reset");
		check_flag(ack, 1'b0, "ack after reset");
	endtask : do_reset

	task automatic expect_write(input logic [14:0] a, input logic [7:0] d, input logic b);
		for (int i = 0; i < 8 && n_wr == 0; i++) host.tick(1);
		check_word(15'(n_wr), 15'h0001, "write pulses");
		check_word(w_addr, a, "write address");
		check_word({7'h00, w_data}, {7'h00, d}, "write data");
		check_flag(w_be, b, "byte enable");
	endtask : expect_write

	// Strobe low drives the bus; strobe and select going high together must release it
	task automatic async_read(input logic [14:0] a, input logic [7:0] d);
		host.cs_n_out = 1'b0;
		host.strobe_n_out = 1'b0;
		for (int i = 0; i < 8 && oe_n !== 1'b0; i++) host.tick(1);
		check_word({7'h00, dout}, {7'h00, d}, "read data");
		check_flag(ack, 1'b1, "ack while driving");
		check_word(r_addr, a, "read address");
		host.tick(6);
		check_flag(oe_n, 1'b0, "bus held while strobe low");
		host.strobe_n_out = 1'b1;
		host.cs_n_out = 1'b1;
		host.tick(4);
		check_flag(oe_n, 1'b1, "bus released");
		check_flag(ack, 1'b0, "ack dropped");
	endtask : async_read

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_latch();
		do_reset(HPF_SEL_ASYNC_LATCH);
		host.cs_n_out = 1'b0;
		host.host_period();
		host.host_period();
		check_word(15'(n_wr + n_rd), 15'h0000, "host clock in async mode");
		host.latch_addr(15'h5a3c);
		host.wdata = 8'hc3;
		host.drive = 1'b1;
		host.wr_out = 1'b0;
		host.tick(3);
		host.wr_out = 1'b1;
		expect_write(15'h5a3c, 8'hc3, 1'b1);
		host.drive = 1'b0;
		host.cs_n_out = 1'b1;
		host.latch_addr(15'h5a3c);
		async_read(15'h5a3c, 8'hc3);
		$display("latch test done");
	endtask : test_latch

	task automatic test_strobe();
		do_reset(HPF_SEL_ASYNC_STROBE);
		host.strobe_addr(15'h0123);
		host.wr_out = 1'b0;
		host.wdata = 8'h5e;
		host.drive = 1'b1;
		host.cs_n_out = 1'b0;
		host.strobe_n_out = 1'b0;
		host.tick(3);
		host.strobe_n_out = 1'b1;
		expect_write(15'h0123, 8'h5e, 1'b1);
		host.cs_n_out = 1'b1;
		host.drive = 1'b0;
		host.wr_out = 1'b1;
		host.strobe_addr(15'h0123);
		async_read(15'h0123, 8'h5e);
		$display("strobe test done");
	endtask : test_strobe

	// Write held for cycles without a host edge must not land
	task automatic test_sync(input logic [2:0] code);
		do_reset(code);
		host.addr_out = 15'h2a55;
		host.wdata = 8'ha6;
		host.drive = 1'b1;
		host.be_out = 1'b0;
		host.cs_n_out = 1'b0;
		host.wr_out = 1'b0;
		host.strobe_n_out = 1'b0;
		host.tick(6);
		check_word(15'(n_wr), 15'h0000, "write before host edge");
		host.host_period();
		host.addr_out = 15'h7fff;
		host.cs_n_out = 1'b1;
		host.strobe_n_out = 1'b1;
		host.drive = 1'b0;
		host.wr_out = 1'b1;
		host.be_out = 1'b1;
		expect_write(15'h2a55, 8'ha6, 1'b0);
		host.addr_out = 15'h2a55;
		host.cs_n_out = 1'b0;
		host.host_period();
		host.cs_n_out = 1'b1;
		host.host_clk_out = 1'b1;
		host.tick(1);
		check_flag(ack, 1'b0, "ack before host edge seen");
		host.tick(3);
		host.host_clk_out = 1'b0;
		host.tick(2);
		check_flag(ack, 1'b1, "sync ack");
		check_word({7'h00, dout}, {7'h00, 8'ha6}, "sync read data");
		check_word(r_addr, 15'h2a55, "sync read address");
		host.tick(2);
		host.host_clk_out = 1'b1;
		host.tick(1);
		check_flag(ack, 1'b1, "ack stands a host period");
		host.tick(3);
		host.host_clk_out = 1'b0;
		host.tick(4);
		check_flag(ack, 1'b0, "sync ack dropped");
		check_flag(oe_n, 1'b1, "sync bus released");
		$display("sync test done");
	endtask : test_sync

	task automatic test_silent();
		for (int i = 1; i < 7; i++) begin
			if (i != 3 && i != 5) begin
				do_reset(3'(i));
				host.cs_n_out = 1'b0;
				host.strobe_n_out = 1'b0;
				host.wr_out = 1'b0;
				host.host_period();
				host.wr_out = 1'b1;
				host.strobe_n_out = 1'b1;
				host.host_period();
				check_word(15'(n_wr + n_rd), 15'h0000, "silent code access");
				check_flag(oe_n, 1'b1, "silent code bus");
			end
		end
		$display("silent test done");
	endtask : test_silent

	task automatic wrap_up();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	initial begin
		test_latch();
		test_strobe();
		test_sync(HPF_SEL_SYNC_STD);
		test_sync(HPF_SEL_SYNC_EMB);
		test_silent();
		wrap_up();
	end
endmodule : host_processor_port_front_end_test

`default_nettype wire

// ===== hpf_host_model.sv
/*
 * Behavioural host processor that drives the port pins of the front end.
 * Assumes the bench calls its tasks and that pins change 1 ns after a core clock edge.
 */
`default_nettype none

module hpf_host_model
	import hpf_pkg::*;
(
	input wire logic clk_in,
	input wire logic [7:0] dev_data_in,
	input wire logic dev_oe_n_in,
	output var logic host_clk_out,
	output var logic [2:0] sel_out,
	output var logic cs_n_out,
	output var logic wr_out,
	output var logic [14:0] addr_out,
	output var logic [7:0] data_out,
	output var logic strobe_n_out,
	output var logic be_out,
	output var logic acs_out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic drive = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] last_q = 8'h00;

	// ----------------------------------------
	// Data bus
	// ----------------------------------------
	// Released bus toggles every cycle, so stale read data can never pass
	always_comb begin
		if (drive) begin
			data_out = wdata;
		end else if (!dev_oe_n_in) begin
			data_out = dev_data_in;
		end else begin
			data_out = ~last_q;
		end
	end

	// Remember last bus level for the release pattern
	always @(posedge clk_in) begin
		last_q <= data_out;
	end

	// ----------------------------------------
	// Bus cycle tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick

	// Straps only change here, while reset is held
	task automatic idle(input logic [2:0] code);
		sel_out = code;
		host_clk_out = 1'b0;
		cs_n_out = 1'b1;
		wr_out = 1'b1;
		addr_out = 15'h0000;
		strobe_n_out = 1'b1;
		be_out = 1'b1;
		acs_out = (code == HPF_SEL_ASYNC_STROBE);
		drive = 1'b0;
	endtask : idle

	// Address goes away after the closing edge, so only a real latch keeps it
	task automatic latch_addr(input logic [14:0] a);
		acs_out = 1'b1;
		addr_out = a;
		tick(3);
		acs_out = 1'b0;
		tick(3);
		addr_out = ~a;
	endtask : latch_addr

	task automatic strobe_addr(input logic [14:0] a);
		acs_out = 1'b0;
		addr_out = a;
		tick(3);
		acs_out = 1'b1;
		tick(3);
		addr_out = ~a;
	endtask : strobe_addr

	// One host clock period of eight core cycles, 2.5 MHz, well under the limit
	task automatic host_period();
		host_clk_out = 1'b1;
		tick(4);
		host_clk_out = 1'b0;
		tick(4);
	endtask : host_period

	initial begin
		idle(3'h0);
	end
endmodule : hpf_host_model

`default_nettype wire

// ===== hpf_host_port.sv
/*
 * Host processor port front end: personality decode, address capture, read and write
 * sequencing, data bus drive and transfer acknowledge.
 * Assumes a back end on clk_in that answers access_read_out with access_rdata_in in the same cycle.
 */
`default_nettype none

module hpf_host_port
	import hpf_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic host_clk_in,
	input wire logic [2:0] host_personality_select_in,
	input wire logic chip_select_n_in,
	input wire logic write_or_rw_in,
	input wire logic [14:0] host_addr_in,
	input wire logic [7:0] host_data_in,
	input wire logic read_or_data_strobe_n_in,
	input wire logic host_byte_enable_in,
	input wire logic address_capture_strobe_in,
	output var logic [7:0] host_data_out,
	output var logic host_data_oe_n_out,
	output var logic transfer_acknowledge_out,
	output var logic [14:0] access_addr_out,
	output var logic [7:0] access_wdata_out,
	output var logic access_write_out,
	output var logic access_read_out,
	output var logic access_byte_enable_out,
	input wire logic [7:0] access_rdata_in
);

	hpf_sync_if sif();

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	hpf_pin_sync u_sync (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pins_in({host_clk_in, chip_select_n_in, write_or_rw_in, host_addr_in, host_data_in,
			read_or_data_strobe_n_in, host_byte_enable_in, address_capture_strobe_in,
			host_personality_select_in}),
		.sync_out(sif)
	);

	hpf_mode_t mode_q, mode_d;
	hpf_state_t state_q, state_d;
	logic hclk_prev_q, hclk_prev_d;
	logic cap_prev_q, cap_prev_d;
	logic strobe_prev_q, strobe_prev_d;
	logic wr_prev_q, wr_prev_d;
	logic [14:0] addr_q, addr_d;
	logic [7:0] dout_q, dout_d;
	logic oe_n_q, oe_n_d;
	logic ack_q, ack_d;
	logic [14:0] acc_addr_q, acc_addr_d;
	logic [7:0] acc_wdata_q, acc_wdata_d;
	logic acc_wr_q, acc_wr_d;
	logic acc_rd_q, acc_rd_d;
	logic acc_be_q, acc_be_d;
	logic hclk_rise, cap_fall, cap_rise, strobe_rise, wr_rise, selected;

	// ----------------------------------------
	// Personality and edge detection
	// ----------------------------------------
	// Personality follows the straps while reset is held, then freezes
	always_comb begin
		mode_d = reset_in ? hpf_decode_mode(sif.host_personality_select) : mode_q; // RULE6
		hclk_prev_d = sif.host_clk;
		cap_prev_d = sif.address_capture_strobe;
		strobe_prev_d = sif.read_or_data_strobe_n;
		wr_prev_d = sif.write_or_rw;
	end

	always_ff @(posedge clk_in) begin
		mode_q <= mode_d;
		// Capture strobe idles high or low with the personality, so its history is never forced
		cap_prev_q <= cap_prev_d;
		if (reset_in) begin
			hclk_prev_q <= 1'b0;
			strobe_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
		end else begin
			hclk_prev_q <= hclk_prev_d;
			strobe_prev_q <= strobe_prev_d;
			wr_prev_q <= wr_prev_d;
		end
	end

	// Host clock is sampled by clk_in, so a host clock edge is only seen if each phase
	// lasts two core cycles; faster host clocks are a known limit of this front end. RULE4
	assign hclk_rise = (mode_q == HPF_SYNC) && sif.host_clk && !hclk_prev_q; // RULE1 RULE5
	assign cap_fall = !sif.address_capture_strobe && cap_prev_q;
	assign cap_rise = sif.address_capture_strobe && !cap_prev_q;
	assign strobe_rise = sif.read_or_data_strobe_n && !strobe_prev_q;
	assign wr_rise = sif.write_or_rw && !wr_prev_q;
	assign selected = !sif.chip_select_n;

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	// Address latches are transparent while their strobe is active so an access made
	// during the strobe already sees the address; the value freezes on the closing edge
	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		dout_d = dout_q;
		oe_n_d = oe_n_q;
		ack_d = ack_q;
		acc_addr_d = acc_addr_q;
		acc_wdata_d = acc_wdata_q;
		acc_wr_d = 1'b0;
		acc_rd_d = 1'b0;
		acc_be_d = acc_be_q;
		if (mode_q == HPF_ASYNC_LATCH && sif.address_capture_strobe) begin
			addr_d = sif.addr; // RULE10
		end else if (mode_q == HPF_ASYNC_STROBE && !sif.address_capture_strobe) begin
			addr_d = sif.addr; // RULE11
		end else if (hclk_rise) begin
			addr_d = sif.addr; // RULE2
		end
		unique case (state_q)
			HPF_ST_IDLE: begin
				if (mode_q == HPF_SYNC) begin
					if (hclk_rise && selected) begin
						acc_addr_d = sif.addr; // RULE7
						acc_wdata_d = sif.data; // RULE2
						acc_be_d = sif.host_byte_enable;
						if (!sif.read_or_data_strobe_n && !sif.write_or_rw) begin
							acc_wr_d = 1'b1; // RULE8
						end else if (sif.write_or_rw) begin
							acc_rd_d = 1'b1;
							state_d = HPF_ST_SYNC_WAIT;
						end
					end
				end else if (mode_q != HPF_NO_PORT) begin
					acc_addr_d = addr_d; // RULE7
					acc_wdata_d = sif.data;
					acc_be_d = 1'b1;
					if (selected && !sif.read_or_data_strobe_n &&
						(mode_q == HPF_ASYNC_LATCH || sif.write_or_rw)) begin
						acc_rd_d = 1'b1; // RULE9
						state_d = HPF_ST_READ_ISSUE;
					end else if (mode_q == HPF_ASYNC_LATCH && selected && wr_rise) begin
						acc_wr_d = 1'b1;
					end else if (mode_q == HPF_ASYNC_STROBE && selected && strobe_rise && !sif.write_or_rw) begin
						acc_wr_d = 1'b1;
					end
				end
			end
			HPF_ST_READ_ISSUE: begin
				dout_d = access_rdata_in;
				oe_n_d = 1'b0; // RULE9
				ack_d = 1'b1;
				state_d = HPF_ST_DRIVE;
			end
			HPF_ST_DRIVE: begin
				if (sif.read_or_data_strobe_n || !selected) begin
					oe_n_d = 1'b1; // RULE9
					ack_d = 1'b0;
					state_d = HPF_ST_IDLE;
				end
			end
			HPF_ST_SYNC_WAIT: begin
				// Outputs move only on a host clock edge
				if (hclk_rise) begin
					dout_d = access_rdata_in; // RULE3
					oe_n_d = 1'b0;
					ack_d = 1'b1;
					state_d = HPF_ST_SYNC_ACK;
				end
			end
			HPF_ST_SYNC_ACK: begin
				if (hclk_rise) begin
					oe_n_d = 1'b1; // RULE3
					ack_d = 1'b0;
					state_d = HPF_ST_IDLE;
				end
			end
			default: begin
				state_d = HPF_ST_IDLE;
				oe_n_d = 1'b1;
				ack_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q <= HPF_ST_IDLE;
			addr_q <= HPF_ADDR_RST;
			dout_q <= HPF_DATA_RST;
			oe_n_q <= 1'b1;
			ack_q <= 1'b0;
			acc_addr_q <= HPF_ADDR_RST;
			acc_wdata_q <= HPF_DATA_RST;
			acc_wr_q <= 1'b0;
			acc_rd_q <= 1'b0;
			acc_be_q <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
			oe_n_q <= oe_n_d;
			ack_q <= ack_d;
			acc_addr_q <= acc_addr_d;
			acc_wdata_q <= acc_wdata_d;
			acc_wr_q <= acc_wr_d;
			acc_rd_q <= acc_rd_d;
			acc_be_q <= acc_be_d;
		end
	end

	// Outputs straight from flip-flops
	assign host_data_out = dout_q;
	assign host_data_oe_n_out = oe_n_q;
	assign transfer_acknowledge_out = ack_q;
	assign access_addr_out = acc_addr_q;
	assign access_wdata_out = acc_wdata_q;
	assign access_write_out = acc_wr_q;
	assign access_read_out = acc_rd_q;
	assign access_byte_enable_out = acc_be_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_async_req;
		mode_q == HPF_ASYNC_LATCH && state_q == HPF_ST_IDLE && selected && !sif.read_or_data_strobe_n;
	endsequence

	sequence s_drive;
		access_read_out ##1 (!host_data_oe_n_out && transfer_acknowledge_out);
	endsequence

	a_async_clk_ignored: assert property ((mode_q != HPF_SYNC && state_q == HPF_ST_IDLE && // RULE5
		sif.host_clk && !hclk_prev_q && selected && sif.read_or_data_strobe_n && strobe_prev_q &&
		sif.write_or_rw && wr_prev_q) |=> !access_write_out && !access_read_out)
		else $error("host clock acted in an asynchronous personality");
	a_sync_write_edge: assert property ((hclk_rise && state_q == HPF_ST_IDLE && selected && // RULE8
		!sif.read_or_data_strobe_n && !sif.write_or_rw) |=> access_write_out && access_wdata_out == $past(sif.data))
		else $error("synchronous write not stored on sampled edge");
	a_sync_out_step: assert property ((mode_q == HPF_SYNC && !$past(hclk_rise)) |-> // RULE3
		$stable(host_data_out) && $stable(transfer_acknowledge_out) && $stable(host_data_oe_n_out))
		else $error("synchronous outputs moved between host clock edges");
	a_sync_ack_edge: assert property ((mode_q == HPF_SYNC && $rose(transfer_acknowledge_out)) |-> // RULE1
		$past(hclk_rise) && !host_data_oe_n_out)
		else $error("acknowledge rose without a host clock edge");
	a_async_read_drive: assert property (s_async_req |=> s_drive ##0 host_data_out == $past(access_rdata_in)) // RULE9
		else $error("read data not driven after read strobe");
	a_async_release: assert property ((state_q == HPF_ST_DRIVE && sif.read_or_data_strobe_n) |=> // RULE9
		host_data_oe_n_out ##1 host_data_oe_n_out)
		else $error("data bus not released after read strobe");
	a_latch_addr_hold: assert property ((mode_q == HPF_ASYNC_LATCH && cap_fall) |=> // RULE10
		addr_q == $past(addr_q) && addr_q == $past(sif.addr, 2))
		else $error("address not captured on latch strobe fall");
	a_strobe_addr_hold: assert property ((mode_q == HPF_ASYNC_STROBE && cap_rise) |=> // RULE11
		addr_q == $past(addr_q) && addr_q == $past(sif.addr, 2))
		else $error("address not captured on address strobe rise");
	a_access_addr: assert property ((access_write_out && mode_q == HPF_ASYNC_LATCH) |-> // RULE7
		access_addr_out == addr_q)
		else $error("access address differs from captured address");
	a_mode_frozen: assert property (!$past(reset_in) |-> $stable(mode_q)) // RULE6
		else $error("personality changed outside reset");

endmodule : hpf_host_port

`default_nettype wire

// ===== hpf_pin_sync.sv
/*
 * Two-stage synchroniser for every host pin, host clock included.
 * Assumes pins are asynchronous to clk_in; all bits share one skew so edges stay aligned.
 */
`default_nettype none

module hpf_pin_sync
	import hpf_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [31:0] pins_in,
	hpf_sync_if.sync sync_out
);

	logic [31:0] stage1_q;
	logic [31:0] stage1_d;
	logic [31:0] stage2_q;
	logic [31:0] stage2_d;

	// ----------------------------------------
	// Synchroniser stages
	// ----------------------------------------
	// Stage one feeds stage two only, never logic
	always_comb begin
		stage1_d = pins_in;
		stage2_d = stage1_q;
	end

	always_ff @(posedge clk_in) begin
		// Pins read as idle during reset, but the straps and the capture strobe keep moving:
		// the personality is frozen from them at the last reset edge, and forcing the strobe
		// would hand the core a false capture edge once reset ends
		if (reset_in) begin
			stage1_q <= {HPF_PIN_IDLE[31:4], stage1_d[3:0]};
			stage2_q <= {HPF_PIN_IDLE[31:4], stage2_d[3:0]};
		end else begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
		end
	end

	// Unpack into named signals
	assign sync_out.host_clk = stage2_q[31];
	assign sync_out.chip_select_n = stage2_q[30];
	assign sync_out.write_or_rw = stage2_q[29];
	assign sync_out.addr = stage2_q[28:14];
	assign sync_out.data = stage2_q[13:6];
	assign sync_out.read_or_data_strobe_n = stage2_q[5];
	assign sync_out.host_byte_enable = stage2_q[4];
	assign sync_out.address_capture_strobe = stage2_q[3];
	assign sync_out.host_personality_select = stage2_q[2:0];

endmodule : hpf_pin_sync

`default_nettype wire

// ===== hpf_pkg.sv
/*
 * Constants, types and decode helpers for the host processor port front end.
 * Assumes one 20 MHz core clock and a host bus on pins outside that clock's domain.
 */
// Summary of operation
// [RULE1] Host bus clock is used only in synchronous bus personalities.
// [RULE2] Synchronous modes sample select, strobes, address, data, byte enable on host clock.
// [RULE3] Synchronous modes change data outputs and acknowledge only on host clock edges.
// [RULE4] Port works with host clocks up to the stated maximum; host never exceeds it. Code sees host edges only with two-cycle phases, 5 MHz.
// [RULE5] Asynchronous personalities ignore the host clock; board ties it low.
// [RULE6] Personality comes from three select inputs; 000 latch style, 111 synchronous.
// [RULE7] Fifteen-bit address on every access selects one on-chip location.
// [RULE8] Synchronous write stores data when strobe, select and read-write sampled asserted.
// [RULE9] Latch style read drives data while read strobe low, releases when high.
// [RULE10] Latch style captures address on falling edge of the active-high latch strobe.
// [RULE11] Strobe style captures address on rising edge of the active-low address strobe.
// [RULE12] Board holds select inputs fixed from reset; personality treated as constant.
`default_nettype none

package hpf_pkg;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int HPF_ADDR_W = 15;
	localparam int HPF_DATA_W = 8;
	localparam int HPF_SEL_W = 3;
	localparam int HPF_PIN_W = 32;
	localparam logic [14:0] HPF_ADDR_RST = 15'h0000;
	localparam logic [7:0] HPF_DATA_RST = 8'h00;
	// Synchronised pin word while reset is held: select, read or data strobe and write high, clock low
	localparam logic [31:0] HPF_PIN_IDLE = 32'h6000_0020;

	// ----------------------------------------
	// Personality select codes
	// ----------------------------------------
	localparam logic [2:0] HPF_SEL_ASYNC_LATCH = 3'h0;
	localparam logic [2:0] HPF_SEL_ASYNC_STROBE = 3'h3;
	localparam logic [2:0] HPF_SEL_SYNC_STD = 3'h5;
	localparam logic [2:0] HPF_SEL_SYNC_EMB = 3'h7;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int HPF_CLK_PERIOD_NS = 50;
	localparam int HPF_HOST_CLK_MAX_MHZ = 33;
	localparam int HPF_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		HPF_ASYNC_LATCH = 2'b00,
		HPF_ASYNC_STROBE = 2'b01,
		HPF_SYNC = 2'b10,
		HPF_NO_PORT = 2'b11
	} hpf_mode_t;

	typedef enum logic [2:0] {
		HPF_ST_IDLE = 3'b000,
		HPF_ST_READ_ISSUE = 3'b001,
		HPF_ST_DRIVE = 3'b010,
		HPF_ST_SYNC_WAIT = 3'b011,
		HPF_ST_SYNC_ACK = 3'b100
	} hpf_state_t;

	// Codes with no known meaning leave the port silent
	function automatic hpf_mode_t hpf_decode_mode(input logic [2:0] sel);
		hpf_mode_t m;
		m = HPF_NO_PORT;
		if (sel == HPF_SEL_ASYNC_LATCH) begin
			m = HPF_ASYNC_LATCH;
		end else if (sel == HPF_SEL_ASYNC_STROBE) begin
			m = HPF_ASYNC_STROBE;
		end else if (sel == HPF_SEL_SYNC_STD || sel == HPF_SEL_SYNC_EMB) begin
			m = HPF_SYNC;
		end
		return m;
	endfunction : hpf_decode_mode

endpackage : hpf_pkg

`default_nettype wire

// ===== hpf_sync_if.sv
/*
 * Bundle of host pins after synchronisation, from the pin synchroniser to the core.
 * Assumes both ends run on the same core clock.
 */
`default_nettype none

interface hpf_sync_if;
	logic host_clk;
	logic chip_select_n;
	logic write_or_rw;
	logic [14:0] addr;
	logic [7:0] data;
	logic read_or_data_strobe_n;
	logic host_byte_enable;
	logic address_capture_strobe;
	logic [2:0] host_personality_select;

	modport sync (output host_clk, chip_select_n, write_or_rw, addr, data, read_or_data_strobe_n,
		host_byte_enable, address_capture_strobe, host_personality_select);
	modport core (input host_clk, chip_select_n, write_or_rw, addr, data, read_or_data_strobe_n,
		host_byte_enable, address_capture_strobe, host_personality_select);
endinterface : hpf_sync_if

`default_nettype wire
